// File: rtl/tkel_core.sv
// tkel_core: touch key event logic with its apb register file
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tkel_core #(
    parameter int unsigned AC8_CYCLES   = tkel_pkg::AC8_CYC,
    parameter int unsigned AC32_CYCLES  = tkel_pkg::AC32_CYC,
    parameter int unsigned RECAL_CYCLES = tkel_pkg::RECAL_CYC
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       pclken,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tkel_pkg::AW-1:0]    paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [tkel_pkg::NCH-1:0]   sense_input,
    input  wire logic                       shutdown_n,
    input  wire logic [1:0]                 addr_strap,
    output logic      [2:0]                 key_out_n_o,
    output logic      [2:0]                 key_out_n_oe,
    output logic                            key_out_ch4_n_o,
    output logic                            key_out_ch4_n_oe,
    output logic                            event_irq_n,
    output logic                            irq,
    output logic      [6:0]                 slave_addr
);
    import tkel_pkg::*;

    logic [SYNC_W-1:0]   pins_raw;
    logic [SYNC_W-1:0]   sync1;
    logic [SYNC_W-1:0]   sync2;
    logic [SYNC_W-1:0]   sync3;
    logic [SYNC_W-1:0]   pins;
    logic [NCH-1:0]      sense_f;
    logic [1:0]          strap_f;
    logic                run;
    logic [2:0]          strap_wait;
    logic                strap_done;
    logic                cfg_ssd;
    logic [1:0]          cfg_ss;
    logic [7:0]          chen;
    logic [1:0]          irq_autoclear_sel;
    logic [IST_W-1:0]    imask;
    logic [IST_W-1:0]    istat;
    logic [IST_W-1:0]    ist_set;
    logic [NCH-1:0]      key_state;
    logic [NCH-1:0]      base;
    logic [NCH-1:0]      ch_on;
    logic [NCH-1:0]      flip;
    logic [NCH-1:0]      recal;
    logic [NCH-1:0]      ev_touch;
    logic [NCH-1:0]      ev_rel;
    logic [NCH-1:0]      ev;
    logic [NCH-1:0]      change_flag;
    logic [NCH-1:0]      chg_clr;
    logic [3:0]          deb_cnt [NCH];
    logic [CNT_W-1:0]    hold_cnt [NCH];
    logic [3:0]          deb_lim;
    logic [CNT_W-1:0]    ac_cnt;
    logic [CNT_W-1:0]    ac_lim;
    logic                ac_auto;
    logic                ac_hit;
    logic [2:0]          idx;
    logic                hit;
    logic                armed;
    logic                chg_sel;
    logic                wr_en;
    logic                rd_chg;
    logic [31:0]         rd_val;

    ////////////////////////////////////////////////////////////////////////////
    // pin inputs: three stages, a change counts once stages two and three agree
    assign pins_raw = {addr_strap, shutdown_n, sense_input};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pins  <= '0;
        end else if (pclken) begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pins  <= (pins & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
        end
    end

    assign sense_f = pins[NCH-1:0];
    assign strap_f = pins[NCH+2:NCH+1];
    // pin shutdown or software shutdown both stop the block
    assign run     = pins[NCH] & ~cfg_ssd; // RULE4

    ////////////////////////////////////////////////////////////////////////////
    // address strap is caught once the filter has settled after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_wait <= 3'h0;
            strap_done <= 1'b0;
            slave_addr <= {SADDR_HI, STRAP_GND};
        end else if (pclken && !strap_done) begin
            if (strap_wait == STRAP_WAIT) begin
                strap_done <= 1'b1;
                slave_addr <= {SADDR_HI, strap_f}; // RULE6 RULE8
            end else begin
                strap_wait <= strap_wait + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; read data is sampled in the setup cycle so it comes from flops
    assign idx     = paddr[ADDR_LSB+2:ADDR_LSB];
    assign hit     = (paddr[AW-1:ADDR_LSB+3] == '0) && (paddr[ADDR_LSB-1:0] == 2'h0);
    assign pready  = pclken & armed;
    assign wr_en   = psel & penable & pwrite & pready & hit;
    assign rd_chg  = psel & penable & ~pwrite & pready & chg_sel;
    // only bits that were reported get cleared, so a late event is never lost
    assign chg_clr = rd_chg ? prdata[NCH-1:0] : '0; // RULE10

    always_comb begin
        rd_val = '0;
        case (idx)
            IDX_CFG:   rd_val[7:0] = {cfg_ssd, cfg_ss, 5'h00};
            IDX_CHEN:  rd_val[7:0] = chen;
            IDX_AS:    rd_val[NCH-1:0] = key_state;
            IDX_CHG:   rd_val[NCH-1:0] = change_flag;
            IDX_INT:   rd_val[7:0] = {irq_autoclear_sel, 6'h00};
            IDX_ISTAT: rd_val[IST_W-1:0] = istat;
            IDX_IMASK: rd_val[IST_W-1:0] = imask;
            IDX_SADDR: rd_val[6:0] = slave_addr;
            default:   rd_val = '0;
        endcase
        if (!hit) begin
            rd_val = '0;
        end
    end

    // answer latched in setup, released at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
            armed   <= 1'b0;
            chg_sel <= 1'b0;
        end else if (pclken) begin
            if (psel && !penable) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr <= ~hit;
                armed   <= 1'b1;
                chg_sel <= ~pwrite & hit & (idx == IDX_CHG);
            end else if (psel && penable && armed) begin
                armed <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers; read-only offsets ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ssd <= 1'b0;
            cfg_ss  <= SS_NORMAL;
            chen    <= CHEN_RST; // RULE11
            irq_autoclear_sel     <= ACI_NONE;
            imask   <= IMASK_RST;
        end else if (wr_en) begin
            case (idx)
                IDX_CFG: begin
                    cfg_ssd <= pwdata[CFG_SSD_BIT];
                    cfg_ss  <= pwdata[CFG_SS_LSB+:2];
                end
                IDX_CHEN:  chen  <= pwdata[7:0]; // RULE11
                IDX_INT:   irq_autoclear_sel   <= pwdata[INT_ACI_LSB+:2]; // RULE2
                IDX_IMASK: imask <= pwdata[IST_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // calibration: debounce against a tracked baseline, rebaseline on long hold
    always_comb begin
        case (cfg_ss)
            SS_HIGH: deb_lim = DEB_HIGH;
            SS_LOW:  deb_lim = DEB_LOW;
            default: deb_lim = DEB_NORMAL;
        endcase
    end

    // a cleared enable bit silences a floating channel
    assign ch_on = {NCH{run}} & chen[NCH-1:0]; // RULE5 RULE11

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            flip[i]  = ch_on[i] && ((sense_f[i] ^ base[i]) != key_state[i])
                       && (deb_cnt[i] == deb_lim - 4'h1);
            recal[i] = ch_on[i] && (sense_f[i] ^ base[i])
                       && (hold_cnt[i] >= CNT_W'(RECAL_CYCLES - 1)); // RULE7
        end
    end

    // a rebaseline of a pressed key is reported as a release
    assign ev_touch = flip & ~key_state & ~recal;
    assign ev_rel   = (flip & key_state & ~recal) | (recal & key_state);
    assign ev       = ev_touch | ev_rel; // RULE1

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_state <= '0;
            base      <= '0;
            for (int i = 0; i < NCH; i++) begin
                deb_cnt[i]  <= 4'h0;
                hold_cnt[i] <= '0;
            end
        end else if (pclken) begin
            for (int i = 0; i < NCH; i++) begin
                if (!ch_on[i] || recal[i]) begin
                    // idle level becomes the new baseline
                    key_state[i] <= 1'b0; // RULE4
                    base[i]      <= sense_f[i]; // RULE7
                    deb_cnt[i]   <= 4'h0;
                    hold_cnt[i]  <= '0;
                end else begin
                    if (flip[i]) begin
                        key_state[i] <= ~key_state[i];
                        deb_cnt[i]   <= 4'h0;
                    end else if ((sense_f[i] ^ base[i]) != key_state[i]) begin
                        deb_cnt[i] <= deb_cnt[i] + 4'h1;
                    end else begin
                        deb_cnt[i] <= 4'h0;
                    end
                    if (sense_f[i] ^ base[i]) begin
                        hold_cnt[i] <= hold_cnt[i] + CNT_W'(1);
                    end else begin
                        hold_cnt[i] <= '0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // open-drain key outputs: only the enable moves, the driven level is low
    assign key_out_n_o     = 3'h0;
    assign key_out_ch4_n_o = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_out_n_oe     <= 3'h0;
            key_out_ch4_n_oe <= 1'b0;
        end else if (pclken) begin
            key_out_n_oe     <= key_state[2:0]; // RULE3
            key_out_ch4_n_oe <= key_state[3]; // RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // change flags: a new event wins over the clear of a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_flag <= '0;
        end else if (pclken) begin
            change_flag <= (change_flag & ~chg_clr) | ev; // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event interrupt pin with auto-clear timer; code 11 behaves as no clear
    assign ac_auto = (irq_autoclear_sel == ACI_8MS) || (irq_autoclear_sel == ACI_32MS); // RULE2
    assign ac_lim  = (irq_autoclear_sel == ACI_8MS) ? CNT_W'(AC8_CYCLES - 1)
                                      : CNT_W'(AC32_CYCLES - 1); // RULE9
    // >= keeps the timer bounded when the mode is shortened mid-count
    assign ac_hit  = ac_auto && !event_irq_n && (ac_cnt >= ac_lim);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_irq_n <= 1'b1;
            ac_cnt      <= '0;
        end else if (pclken) begin
            if (|ev) begin
                event_irq_n <= 1'b0; // RULE1
                ac_cnt      <= '0;
            end else if (!run || ac_hit || rd_chg) begin
                event_irq_n <= 1'b1; // RULE9 RULE12
                ac_cnt      <= '0;
            end else if (!event_irq_n && ac_auto) begin
                ac_cnt <= ac_cnt + CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system interrupt: sticky status, write one to clear, set wins
    assign ist_set[IST_TOUCH] = |ev_touch;
    assign ist_set[IST_REL]   = |ev_rel;
    assign ist_set[IST_ACLR]  = ac_hit & ~(|ev);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat <= '0;
        end else if (pclken) begin
            if (wr_en && (idx == IDX_ISTAT)) begin
                istat <= (istat & ~pwdata[IST_W-1:0]) | ist_set;
            end else begin
                istat <= istat | ist_set;
            end
        end
    end

    assign irq = |(istat & imask);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence ev_seen;
        pclken && (|ev);
    endsequence

    sequence ac_expire;
        pclken && ac_hit && !(|ev);
    endsequence

    sequence stopped_two;
        (pclken && !run) ##1 pclken;
    endsequence

    irq_on_event_a: assert property ( // RULE1
        ev_seen |=> !event_irq_n
    ) else $error("event did not pull the interrupt pin low");

    bad_code_hold_a: assert property ( // RULE2
        pclken && (irq_autoclear_sel == 2'h3) && !event_irq_n && run && !rd_chg && !(|ev)
        |=> !event_irq_n
    ) else $error("invalid auto-clear code released the interrupt");

    key_drive_a: assert property ( // RULE3
        pclken |=> ({key_out_ch4_n_oe, key_out_n_oe} == $past(key_state))
    ) else $error("key output does not follow key state");

    shut_release_a: assert property ( // RULE4
        stopped_two |=> ({key_out_ch4_n_oe, key_out_n_oe} == 4'h0) && event_irq_n
    ) else $error("shutdown left an output asserted");

    strap_take_a: assert property ( // RULE6
        $rose(strap_done) |-> (slave_addr[1:0] == $past(strap_f))
    ) else $error("strap not taken into the slave address");

    addr_fixed_a: assert property ( // RULE8
        strap_done |-> (slave_addr[6:2] == SADDR_HI) ##1 $stable(slave_addr)
    ) else $error("slave address not fixed after strap capture");

    recal_base_a: assert property ( // RULE7
        pclken && (|recal) |=> ((key_state & $past(recal)) == '0)
            && (((base ^ $past(sense_f)) & $past(recal)) == '0)
    ) else $error("rebaseline did not release the channel");

    auto_clear_a: assert property ( // RULE9
        ac_expire |=> event_irq_n && (ac_cnt == '0)
    ) else $error("auto-clear did not release the interrupt");

    change_set_a: assert property ( // RULE10
        ev_seen |=> ((change_flag & $past(ev)) == $past(ev))
    ) else $error("change flag not set by event");

    chan_gate_a: assert property ( // RULE11
        (ev & ~chen[NCH-1:0]) == '0
    ) else $error("disabled channel raised an event");

    no_auto_hold_a: assert property ( // RULE12
        pclken && !event_irq_n && run && (irq_autoclear_sel == ACI_NONE) && !rd_chg
        |=> !event_irq_n
    ) else $error("interrupt released without a status read");

endmodule : tkel_core
`default_nettype wire

// File: rtl/tkel_pkg.sv
// tkel_pkg: constants of the touch key event logic
// Functional notes
// RULE1: interrupt pin goes low on any touch or release of an enabled channel.
// RULE2: software register selects how the interrupt pin is asserted and released. The code's field selects only the release (auto-clear); every event asserts it.
// RULE3: each key output pulls low while its channel is pressed, released otherwise.
// RULE4: shutdown pin low stops sensing and releases outputs; high resumes.
// RULE5: host clears the enable bit of every unused channel.
// RULE6: low slave address bits are chosen by the board strap.
// RULE7: calibration tracks drift and rebaselines channels to avoid false keys.
// RULE8: address is fixed 10001 then two strap bits per strap connection.
// RULE9: auto-clear field: 00 none, 01 after 8 ms, 10 after 32 ms.
// RULE10: per-channel change flag reads one after a touch or release.
// RULE11: channel enable bits, one enables, all four enabled after reset.
// RULE12: without auto-clear the interrupt holds until change flags are read.
`default_nettype none
package tkel_pkg;
    // clock and times
    localparam int unsigned CLK_KHZ   = 25000;
    localparam int unsigned AC8_MS    = 8;
    localparam int unsigned AC32_MS   = 32;
    localparam int unsigned RECAL_MS  = 2000;
    localparam int unsigned AC8_CYC   = AC8_MS * CLK_KHZ;
    localparam int unsigned AC32_CYC  = AC32_MS * CLK_KHZ;
    localparam int unsigned RECAL_CYC = RECAL_MS * CLK_KHZ;
    localparam int          CNT_W     = 26;
    // sizes
    localparam int NCH    = 4;
    localparam int AW     = 8;
    localparam int SYNC_W = 7;
    localparam int IST_W  = 3;
    // register indices, byte address is four times the index
    localparam int          ADDR_LSB  = 2;
    localparam logic [2:0]  IDX_CFG   = 3'h0;
    localparam logic [2:0]  IDX_CHEN  = 3'h1;
    localparam logic [2:0]  IDX_AS    = 3'h2;
    localparam logic [2:0]  IDX_CHG   = 3'h3;
    localparam logic [2:0]  IDX_INT   = 3'h4;
    localparam logic [2:0]  IDX_ISTAT = 3'h5;
    localparam logic [2:0]  IDX_IMASK = 3'h6;
    localparam logic [2:0]  IDX_SADDR = 3'h7;
    // fields
    localparam int CFG_SSD_BIT = 7;
    localparam int CFG_SS_LSB  = 5;
    localparam int INT_ACI_LSB = 6;
    localparam int IST_TOUCH   = 0;
    localparam int IST_REL     = 1;
    localparam int IST_ACLR    = 2;
    // reset values
    localparam logic [7:0]       CHEN_RST  = 8'hff;
    localparam logic [IST_W-1:0] IMASK_RST = 3'h0;
    // auto-clear and sensitivity codes
    localparam logic [1:0] ACI_NONE  = 2'h0;
    localparam logic [1:0] ACI_8MS   = 2'h1;
    localparam logic [1:0] ACI_32MS  = 2'h2;
    localparam logic [1:0] SS_NORMAL = 2'h0;
    localparam logic [1:0] SS_HIGH   = 2'h1;
    localparam logic [1:0] SS_LOW    = 2'h2;
    // debounce samples per sensitivity
    localparam logic [3:0] DEB_NORMAL = 4'h4;
    localparam logic [3:0] DEB_HIGH   = 4'h2;
    localparam logic [3:0] DEB_LOW    = 4'h8;
    // slave address
    localparam logic [4:0] SADDR_HI   = 5'h11;
    localparam logic [1:0] STRAP_GND  = 2'h0;
    localparam logic [1:0] STRAP_VCC  = 2'h3;
    localparam logic [1:0] STRAP_SCL  = 2'h1;
    localparam logic [1:0] STRAP_SDA  = 2'h2;
    localparam logic [2:0] STRAP_WAIT = 3'h4;
endpackage : tkel_pkg
`default_nettype wire

// File: verif/tb.sv
// tb: self-checking bench of the touch key event logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tkel_pkg::*;
    // short counts keep the run brief
    localparam int AC8   = 20;
    localparam int AC32  = 50;
    localparam int RECAL = 200;
    logic             pclk, presetn, shutdown_n;
    logic             pclken = 1'b1;
    logic [3:0]       sense, exp_k;
    logic [1:0]       strap;
    wire logic        psel, penable, pwrite, pready, pslverr, oe4, o4, irq_n, irq;
    wire logic [7:0]  paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic [2:0]  oe, o;
    wire logic [6:0]  saddr;
    wire logic [3:0]  key_lvl;
    int               error_cnt, n_compared, cyc, n;
    logic [32:0]      expq[$];
    logic [31:0]      seed;
    logic [1:0]       codes [4] = '{STRAP_GND, STRAP_VCC, STRAP_SCL, STRAP_SDA};
    logic [1:0]       acis [4] = '{ACI_8MS, ACI_32MS, ACI_NONE, 2'h3};
    int               lims [4] = '{AC8, AC32, 0, 0};
    // open-drain key pins with board pull-ups
    assign key_lvl = {(oe4 & o4) | ~oe4, (oe & o) | ~oe};
    tkel_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready));
    tkel_core #(.AC8_CYCLES(AC8), .AC32_CYCLES(AC32), .RECAL_CYCLES(RECAL)) dut_u (
        .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sense_input(sense), .shutdown_n(shutdown_n), .addr_strap(strap),
        .key_out_n_o(o), .key_out_n_oe(oe), .key_out_ch4_n_o(o4), .key_out_ch4_n_oe(oe4),
        .event_irq_n(irq_n), .irq(irq), .slave_addr(saddr));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    // range compare; an unknown never lands inside the range
    task automatic chk(input string nm, input logic [32:0] lo, input logic [32:0] hi,
                       input logic [32:0] g);
        n_compared++;
        if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1)) begin
            error_cnt++;
            $display("Error %s expected %0h..%0h seen %0h", nm, lo, hi, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        expq.push_back({err, e});
        host_u.xfer(1'b0, a, 32'h0);
    endtask : rd
    // waits for the irq pin (w=0) or key pin w to reach a level, bounded
    task automatic wait_for(input int w, input logic lv, input int mx);
        logic s;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
            s = (w == 0) ? irq_n : key_lvl[w-1];
        end while (s !== lv && n < mx);
        chk("pin_level", lv, lv, s);
    endtask : wait_for
    task automatic press(input int ch, input logic v);
        @(posedge pclk);
        sense[ch] <= v;
    endtask : press
    task automatic do_reset(input logic [1:0] s);
        @(posedge pclk);
        presetn <= 1'b0;
        strap <= s;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : do_reset
    // read results meet the oldest note; also the hang guard
    always @(negedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            chk("timeout", 33'h0, 33'h0, 33'h1);
            stop_test();
        end
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            chk("prdata", expq[0], expq[0], {pslverr, prdata});
            void'(expq.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        shutdown_n = 1'b1;
        sense = 4'h0;
        strap = 2'h0;
        seed = 32'h278c817b;
        foreach (codes[i]) begin
            do_reset(codes[i]);
            chk("saddr", {SADDR_HI, codes[i]}, {SADDR_HI, codes[i]}, saddr);
            rd(8'h1c, {SADDR_HI, codes[i]}, 1'b0);
        end
        rd(8'h04, 32'hff, 1'b0);
        rd(8'h0c, 32'h0, 1'b0);
        rd(8'h21, 32'h0, 1'b1);
        seed = xs(seed);
        host_u.xfer(1'b1, 8'h18, seed);
        rd(8'h18, seed & 32'h7, 1'b0);
        host_u.xfer(1'b1, 8'h18, 32'h0);
        // touch and release every channel
        for (int ch = 0; ch < 4; ch++) begin
            exp_k = 4'hf;
            exp_k[ch] = 1'b0;
            press(ch, 1'b1);
            wait_for(0, 1'b0, 40);
            wait_for(ch + 1, 1'b0, 4);
            rd(8'h0c, 32'h1 << ch, 1'b0);
            @(negedge pclk);
            chk("irq_n", 1, 1, irq_n);
            chk("keys", exp_k, exp_k, key_lvl);
            seed = xs(seed);
            repeat (seed[2:0]) @(posedge pclk);
            press(ch, 1'b0);
            wait_for(0, 1'b0, 40);
            wait_for(ch + 1, 1'b1, 4);
            rd(8'h0c, 32'h1 << ch, 1'b0);
        end
        // sticky status behind the mask, cleared by writing ones
        chk("irq", 0, 0, irq);
        host_u.xfer(1'b1, 8'h18, 32'h7);
        rd(8'h14, 32'h3, 1'b0);
        chk("irq", 1, 1, irq);
        host_u.xfer(1'b1, 8'h14, 32'h3);
        rd(8'h14, 32'h0, 1'b0);
        chk("irq", 0, 0, irq);
        // every auto-clear code
        foreach (acis[i]) begin
            host_u.xfer(1'b1, 8'h10, {acis[i], 6'h0});
            rd(8'h10, {acis[i], 6'h0}, 1'b0);
            press(0, 1'b1);
            wait_for(0, 1'b0, 40);
            if (lims[i] > 0) begin
                wait_for(0, 1'b1, lims[i] + 10);
                chk("clr_delay", lims[i] - 2, lims[i] + 2, n);
            end else begin
                repeat (AC32 + 20) @(negedge pclk);
                chk("irq_n", 0, 0, irq_n);
            end
            press(0, 1'b0);
            wait_for(1, 1'b1, 40);
            rd(8'h0c, 32'h1, 1'b0);
        end
        // a disabled channel gives no key and no event
        host_u.xfer(1'b1, 8'h04, 32'h0e);
        press(0, 1'b1);
        repeat (40) @(negedge pclk);
        chk("irq_n", 1, 1, irq_n);
        chk("keys", 4'hf, 4'hf, key_lvl);
        press(0, 1'b0);
        repeat (10) @(posedge pclk);
        host_u.xfer(1'b1, 8'h04, 32'hff);
        // shutdown releases pins, resume senses again
        press(1, 1'b1);
        wait_for(2, 1'b0, 40);
        @(posedge pclk);
        shutdown_n <= 1'b0;
        wait_for(2, 1'b1, 20);
        chk("irq_n", 1, 1, irq_n);
        press(1, 1'b0);
        repeat (10) @(posedge pclk);
        shutdown_n <= 1'b1;
        repeat (10) @(posedge pclk);
        press(1, 1'b1);
        wait_for(2, 1'b0, 40);
        // a key held past the recalibration time is let go
        wait_for(2, 1'b1, RECAL + 40);
        chk("recal", RECAL - 20, RECAL + 20, n);
        // slow debounce, frozen clock enable, key state readback, software shutdown
        host_u.xfer(1'b1, 8'h00, {SS_LOW, 5'h00});
        rd(8'h00, {SS_LOW, 5'h00}, 1'b0);
        @(posedge pclk);
        pclken <= 1'b0;
        press(2, 1'b1);
        repeat (30) @(posedge pclk);
        chk("frozen", 4'hf, 4'hf, key_lvl);
        pclken <= 1'b1;
        wait_for(3, 1'b0, 40);
        chk("deb_low", DEB_LOW + 5, DEB_LOW + 7, n);
        rd(8'h08, 32'h4, 1'b0);
        host_u.xfer(1'b1, 8'h00, 32'hc0);
        wait_for(3, 1'b1, 10);
        chk("irq_n", 1, 1, irq_n);
        rd(8'h08, 32'h0, 1'b0);
        press(2, 1'b0);
        repeat (10) @(posedge pclk);
        host_u.xfer(1'b1, 8'h00, 32'h0);
        stop_test();
    end
endmodule : tb
`default_nettype wire

// File: verif/tkel_host.sv
// tkel_host: apb master model of the host controller
`timescale 1ns/1ps
`default_nettype none
module tkel_host (
    input  wire logic        pclk,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic [7:0]       paddr = 8'h00,
    output logic [31:0]      pwdata = 32'h0,
    input  wire logic        pready
);
    // pready is taken at the rising edge, before the updates of that edge land
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : tkel_host
`default_nettype wire
